// ### rtl/lpd_pkg.sv
package lpd_pkg;

	// Command and address widths
	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int COL_W  = 10;

	// Bank codes that pick a mode register on a mode load
	localparam logic [1:0] BANK_BASE = 2'h0;
	localparam logic [1:0] BANK_EXT  = 2'h2;

	// Field positions in the loaded word
	localparam int AP_BIT  = 10;
	localparam int DRV_HI  = 6;
	localparam int DRV_LO  = 5;
	localparam int TC_HI   = 4;
	localparam int TC_LO   = 3;
	localparam int PARTIAL_REFRESH_SELECT_HI = 2;
	localparam int PARTIAL_REFRESH_SELECT_LO = 0;
	localparam int BL_HI   = 2;
	localparam int BL_LO   = 0;
	localparam int ROW_B12 = 12;
	localparam int ROW_B11 = 11;

	// Burst length codes
	localparam logic [2:0] BL_2  = 3'h1;
	localparam logic [2:0] BL_4  = 3'h2;
	localparam logic [2:0] BL_8  = 3'h3;
	localparam logic [2:0] BL_16 = 3'h4;

	// Partial refresh select codes
	localparam logic [2:0] PARTIAL_REFRESH_SELECT_ALL  = 3'h0;
	localparam logic [2:0] PARTIAL_REFRESH_SELECT_HALF = 3'h1;
	localparam logic [2:0] PARTIAL_REFRESH_SELECT_QUAR = 3'h2;
	localparam logic [2:0] PARTIAL_REFRESH_SELECT_EIGH = 3'h5;
	localparam logic [2:0] PARTIAL_REFRESH_SELECT_SIXT = 3'h6;

	// Output drive codes
	localparam logic [1:0] DRV_FULL = 2'h0;
	localparam logic [1:0] DRV_HALF = 2'h1;
	localparam logic [1:0] DRV_QUAR = 2'h2;

	// Reset values of the two mode registers
	localparam logic [12:0] BASE_RST = 13'h0031;
	localparam logic [12:0] EXT_RST  = 13'h0000;

	// Retention period and its cycle count
	localparam int SYS_PERIOD_NS = 20;
	localparam int RETAIN_MS     = 64;
	localparam int RETAIN_CYC    = (RETAIN_MS * 1000000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	// Command kinds
	typedef enum logic [2:0] {
		OP_NOP, OP_OPEN, OP_READ, OP_WRITE, OP_BSTOP, OP_CLOSE, OP_REFRESH, OP_MODE
	} lpd_op_t;

	// Power states
	typedef enum logic [1:0] {ST_ACTIVE, ST_SREF, ST_DPD} lpd_state_t;

	// Sampled command pins
	typedef struct packed {
		logic              cke;
		logic              cs_n;
		logic              row_n;
		logic              col_n;
		logic              wr_n;
		logic [1:0]        bank;
		logic [12:0]       addr;
	} lpd_pins_t;

	// Decoded command handed to the system side
	typedef struct packed {
		lpd_op_t           op;
		logic              cke;
		logic [1:0]        bank;
		logic [12:0]       addr;
	} lpd_cmd_t;

endpackage

// ### rtl/lpd_cmd_decode.sv
// Notes on behaviour
// R1 - Burst block from column bits above low 1..4 bits; low bits start, wrap inside.
// R2 - Mode load with bank 10 writes extended register; kept until rewritten.
// R3 - Controller loads extended register only with banks idle, then waits.
// R4 - Controller drives address 7..12 zero on extended load; bits 3,4 ignored.
// R5 - Drive field 6:5: 00 full, 01 half, 10 quarter, 11 reserved; full default.
// R6 - Temperature field 4:3 ignored; die sensor picks self refresh period.
// R7 - Refresh select 2:0 restricts self refresh to all, half, bank0, 1/8, 1/16.
// R8 - Regions left out of self refresh lose data after retention period.
// R9 - Select low: strobe levels decode eight commands; select high deselects.
// R10 - Deselect and no-op behave alike and start nothing.
// R11 - Controller holds clock enable high except self refresh and deep power-down.
// R12 - Open-row takes bank from bank bits and row from address 0..12.
// R13 - Read/write take column 0..9; address 10 sets auto precharge per burst.
// R14 - Burst stop code is deep power-down entry when clock enable low.
// R15 - Controller uses burst stop only for reads without auto precharge.
// R16 - Close-row: bit 10 low one bank, high all banks ignoring bank bits.
// R17 - Refresh code is auto refresh with enable high, self refresh when low.
// R18 - Refresh takes row and bank from an internal counter, inputs ignored.
// R19 - Mode load: bank 00 base, bank 10 extended, others reserved; address is value.
// R20 - Data element written only when its byte mask is low.
// R21 - Bank, address, enable and command pins sampled on link clock rise.
// R22 - Controller changes clock only in power-down, self refresh or clock stop.
// R23 - Controller waits two cycles after a mode load before next command.
// R24 - Controller drives no-op or deselect when it has nothing to issue.
module lpd_cmd_decode #(
	parameter int          DATA_W     = 32,
	parameter int          RETAIN_CYC = lpd_pkg::RETAIN_CYC,
	parameter logic [7:0]  HOT_TEMP   = 8'h50
) (
	// System side
	input  wire logic                  sys_clk_i,
	input  wire logic                  srst_i,
	input  wire logic [7:0]            die_temp_i,
	// Link pins
	input  wire logic                  link_clk_i,
	input  wire logic                  cke_i,
	input  wire logic                  cs_n_i,
	input  wire logic                  row_strobe_n_i,
	input  wire logic                  col_strobe_n_i,
	input  wire logic                  wr_strobe_n_i,
	input  wire logic [1:0]            bank_i,
	input  wire logic [12:0]           addr_i,
	input  wire logic [DATA_W-1:0]     wr_data_i,
	input  wire logic [DATA_W/8-1:0]   write_byte_mask_i,
	// Array write path, link clock
	output logic [DATA_W-1:0]          wr_data_o,
	output logic [DATA_W/8-1:0]        wr_byte_en_o,
	// Decoded command, system clock
	output logic                       cmd_valid_o,
	output lpd_pkg::lpd_op_t           cmd_op_o,
	output logic [1:0]                 cmd_bank_o,
	output logic [12:0]                cmd_addr_o,
	output logic [9:0]                 cmd_col_o,
	output logic                       auto_pre_o,
	output logic                       pre_all_o,
	output logic [9:0]                 burst_base_o,
	output logic [3:0]                 burst_start_o,
	output logic [4:0]                 burst_len_o,
	// Refresh and power state
	output logic [12:0]                refresh_row_o,
	output logic [1:0]                 refresh_bank_o,
	output logic                       self_refresh_o,
	output logic                       deep_pd_o,
	output logic                       sr_fast_o,
	output logic [3:0]                 keep_bank_o,
	output logic                       keep_row12_low_o,
	output logic                       keep_row11_low_o,
	output logic                       region_lost_o,
	// Extended configuration
	output logic [1:0]                 output_drive_select_o,
	output logic [2:0]                 partial_refresh_select_o
);

	// Link domain reset synchroniser
	logic                  lrst_s1_r;
	logic                  lrst_r;
	always_ff @(posedge link_clk_i)
	begin
		lrst_s1_r <= srst_i;
		lrst_r    <= lrst_s1_r;
	end

	// Pins registered on link clock rise
	lpd_pkg::lpd_pins_t    pin_r;
	lpd_pkg::lpd_pins_t    pin_nxt;
	assign pin_nxt = '{cke_i, cs_n_i, row_strobe_n_i, col_strobe_n_i,
		wr_strobe_n_i, bank_i, addr_i};
	always_ff @(posedge link_clk_i)
	begin
		pin_r <= pin_nxt; // [R21]
	end

	// Strobe levels to command kind
	logic [2:0]            strobes;
	lpd_pkg::lpd_op_t      lop;
	logic                  lexec;
	assign strobes = {pin_r.row_n, pin_r.col_n, pin_r.wr_n};
	assign lop = pin_r.cs_n ? lpd_pkg::OP_NOP : // [R9]
		(strobes == 3'h7) ? lpd_pkg::OP_NOP :
		(strobes == 3'h3) ? lpd_pkg::OP_OPEN :
		(strobes == 3'h5) ? lpd_pkg::OP_READ :
		(strobes == 3'h4) ? lpd_pkg::OP_WRITE :
		(strobes == 3'h6) ? lpd_pkg::OP_BSTOP :
		(strobes == 3'h2) ? lpd_pkg::OP_CLOSE :
		(strobes == 3'h1) ? lpd_pkg::OP_REFRESH :
		lpd_pkg::OP_MODE;
	assign lexec = (lop != lpd_pkg::OP_NOP); // [R10]

	// Hold word and toggle toward system side
	lpd_pkg::lpd_cmd_t     xfer_r;
	logic                  ltog_r;
	always_ff @(posedge link_clk_i)
	begin
		if (lrst_r)
		begin
			xfer_r <= '0;
			ltog_r <= 1'b0;
		end
		else if (lexec)
		begin
			xfer_r <= '{lop, pin_r.cke, pin_r.bank, pin_r.addr};
			ltog_r <= ~ltog_r;
		end
	end

	// Write data and byte enables
	always_ff @(posedge link_clk_i)
	begin
		if (lrst_r)
		begin
			wr_data_o    <= '0;
			wr_byte_en_o <= '0;
		end
		else
		begin
			wr_data_o    <= wr_data_i;
			wr_byte_en_o <= ~write_byte_mask_i; // [R20]
		end
	end

	// Toggle and clock enable synchronisers
	logic                  tog_s1_r;
	logic                  tog_s2_r;
	logic                  tog_s3_r;
	logic                  cke_s1_r;
	logic                  cke_s2_r;
	always_ff @(posedge sys_clk_i)
	begin
		tog_s1_r <= ltog_r;
		tog_s2_r <= tog_s1_r;
		tog_s3_r <= tog_s2_r;
		cke_s1_r <= pin_r.cke;
		cke_s2_r <= cke_s1_r;
	end

	// New command arrival and its kind
	logic                  new_cmd;
	logic                  is_mode;
	logic                  is_ref;
	logic                  is_bst;
	logic                  is_rw;
	assign new_cmd = tog_s2_r ^ tog_s3_r;
	assign is_mode = new_cmd && (xfer_r.op == lpd_pkg::OP_MODE);
	assign is_ref  = new_cmd && (xfer_r.op == lpd_pkg::OP_REFRESH);
	assign is_bst  = new_cmd && (xfer_r.op == lpd_pkg::OP_BSTOP);
	assign is_rw   = (xfer_r.op == lpd_pkg::OP_READ) || (xfer_r.op == lpd_pkg::OP_WRITE);

	// Mode registers
	logic [12:0]           base_r;
	logic [12:0]           ext_r;
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			base_r <= lpd_pkg::BASE_RST;
			ext_r  <= lpd_pkg::EXT_RST; // [R5]
		end
		else if (is_mode)
		begin
			if (xfer_r.bank == lpd_pkg::BANK_BASE)
				base_r <= xfer_r.addr; // [R19]
			if (xfer_r.bank == lpd_pkg::BANK_EXT)
				ext_r <= xfer_r.addr; // [R2] [R19]
		end
	end

	// Extended fields; temperature field is never read
	assign output_drive_select_o    = ext_r[lpd_pkg::DRV_HI:lpd_pkg::DRV_LO]; // [R5]
	assign partial_refresh_select_o = ext_r[lpd_pkg::PARTIAL_REFRESH_SELECT_HI:lpd_pkg::PARTIAL_REFRESH_SELECT_LO];
	assign sr_fast_o = (die_temp_i >= HOT_TEMP); // [R6]

	// Regions kept alive in self refresh
	logic [2:0]            partial_refresh_select;
	assign partial_refresh_select = partial_refresh_select_o;
	assign keep_bank_o = (partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_ALL)  ? 4'hF : // [R7]
		(partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_HALF) ? 4'h3 :
		(partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_QUAR) ? 4'h1 :
		(partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_EIGH) ? 4'h1 :
		(partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_SIXT) ? 4'h1 : 4'hF;
	assign keep_row12_low_o = (partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_EIGH) || (partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_SIXT);
	assign keep_row11_low_o = (partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_SIXT);

	// Block size from burst length code
	logic [2:0]            bl_code;
	logic [3:0]            low_mask;
	assign bl_code = base_r[lpd_pkg::BL_HI:lpd_pkg::BL_LO];
	assign low_mask = (bl_code == lpd_pkg::BL_2)  ? 4'h1 : // [R1]
		(bl_code == lpd_pkg::BL_4)  ? 4'h3 :
		(bl_code == lpd_pkg::BL_8)  ? 4'h7 :
		(bl_code == lpd_pkg::BL_16) ? 4'hF : 4'h1;

	// Column, block base and start element
	logic [9:0]            col;
	logic [9:0]            base_nxt;
	logic [3:0]            start_nxt;
	logic [4:0]            len_nxt;
	assign col = xfer_r.addr[lpd_pkg::COL_W-1:0]; // [R13]
	assign base_nxt  = col & ~{6'h00, low_mask}; // [R1]
	assign start_nxt = col[3:0] & low_mask;
	assign len_nxt   = {1'b0, low_mask} + 5'h01;

	// Registered command outputs
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			cmd_valid_o   <= 1'b0;
			cmd_op_o      <= lpd_pkg::OP_NOP;
			cmd_bank_o    <= '0;
			cmd_addr_o    <= '0;
			cmd_col_o     <= '0;
			auto_pre_o    <= 1'b0;
			pre_all_o     <= 1'b0;
			burst_base_o  <= '0;
			burst_start_o <= '0;
			burst_len_o   <= '0;
		end
		else
		begin
			cmd_valid_o <= new_cmd;
			if (new_cmd)
			begin
				cmd_op_o      <= xfer_r.op;
				cmd_bank_o    <= xfer_r.bank; // [R12]
				cmd_addr_o    <= xfer_r.addr; // [R12]
				cmd_col_o     <= col;
				auto_pre_o    <= is_rw && xfer_r.addr[lpd_pkg::AP_BIT]; // [R13]
				pre_all_o     <= (xfer_r.op == lpd_pkg::OP_CLOSE) &&
					xfer_r.addr[lpd_pkg::AP_BIT]; // [R16]
				burst_base_o  <= base_nxt;
				burst_start_o <= start_nxt;
				burst_len_o   <= len_nxt;
			end
		end
	end

	// Internal refresh address counter
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			refresh_row_o  <= '0;
			refresh_bank_o <= '0;
		end
		else if (is_ref && xfer_r.cke)
			{refresh_bank_o, refresh_row_o} <= {refresh_bank_o, refresh_row_o} + 15'h0001; // [R18]
	end

	// Power state machine
	lpd_pkg::lpd_state_t   st_r;
	lpd_pkg::lpd_state_t   st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			lpd_pkg::ST_ACTIVE:
			begin
				if (is_ref && !xfer_r.cke)
					st_nxt = lpd_pkg::ST_SREF; // [R17]
				else if (is_bst && !xfer_r.cke)
					st_nxt = lpd_pkg::ST_DPD; // [R14]
			end
			lpd_pkg::ST_SREF:
			begin
				if (cke_s2_r)
					st_nxt = lpd_pkg::ST_ACTIVE;
			end
			lpd_pkg::ST_DPD:
			begin
				if (cke_s2_r)
					st_nxt = lpd_pkg::ST_ACTIVE;
			end
			default:
				st_nxt = lpd_pkg::ST_ACTIVE;
		endcase
	end
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			st_r <= lpd_pkg::ST_ACTIVE;
		else
			st_r <= st_nxt;
	end
	assign self_refresh_o = (st_r == lpd_pkg::ST_SREF);
	assign deep_pd_o      = (st_r == lpd_pkg::ST_DPD);

	// Retention timer while in self refresh
	logic [31:0]           ret_cnt_r;
	logic                  ret_done;
	assign ret_done = (ret_cnt_r == 32'(RETAIN_CYC - 1));
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || !self_refresh_o)
			ret_cnt_r <= '0;
		else if (!ret_done)
			ret_cnt_r <= ret_cnt_r + 32'h0000_0001;
	end

	// Excluded regions flagged lost, held until reset
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			region_lost_o <= 1'b0;
		else if (self_refresh_o && ret_done && (keep_bank_o != 4'hF))
			region_lost_o <= 1'b1; // [R8]
	end

	// Checks on the system side
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	a_burst_block_wrap: assert property ( // [R1]
		cmd_valid_o |-> ((burst_base_o | {6'h00, burst_start_o}) == cmd_col_o)
			&& ((burst_base_o[3:0] & (burst_len_o[3:0] - 4'h1)) == 4'h0))
		else $error("burst block not aligned to length");

	a_ext_drive_load: assert property ( // [R2]
		(cmd_valid_o && cmd_op_o == lpd_pkg::OP_MODE && cmd_bank_o == lpd_pkg::BANK_EXT)
			|-> (output_drive_select_o == cmd_addr_o[6:5])
			&& (partial_refresh_select_o == cmd_addr_o[2:0]))
		else $error("extended load not taken");

	a_reserved_bank_keep: assert property ( // [R19]
		(new_cmd && xfer_r.op == lpd_pkg::OP_MODE && xfer_r.bank[0])
			|=> $stable(ext_r) && $stable(base_r))
		else $error("reserved bank changed a mode register");

	a_nop_starts_none: assert property ( // [R10]
		cmd_valid_o |-> (cmd_op_o != lpd_pkg::OP_NOP))
		else $error("no-op passed as a command");

	a_auto_pre_bit: assert property ( // [R13]
		(cmd_valid_o && (cmd_op_o == lpd_pkg::OP_READ || cmd_op_o == lpd_pkg::OP_WRITE))
			|-> (auto_pre_o == cmd_addr_o[10]) && (cmd_col_o == cmd_addr_o[9:0]))
		else $error("auto precharge or column wrong");

	a_close_all_banks: assert property ( // [R16]
		(cmd_valid_o && cmd_op_o == lpd_pkg::OP_CLOSE) |-> (pre_all_o == cmd_addr_o[10]))
		else $error("close-row scope wrong");

	a_refresh_count_step: assert property ( // [R18]
		(is_ref && xfer_r.cke) |=> ({refresh_bank_o, refresh_row_o} ==
			{$past(refresh_bank_o), $past(refresh_row_o)} + 15'h0001))
		else $error("refresh counter did not step");

	a_self_ref_entry: assert property ( // [R17]
		(is_ref && !xfer_r.cke && !self_refresh_o && !deep_pd_o) |=> self_refresh_o)
		else $error("self refresh not entered");

	a_deep_pd_entry: assert property ( // [R14]
		(is_bst && !xfer_r.cke && !self_refresh_o && !deep_pd_o) |=> deep_pd_o ##0 !self_refresh_o)
		else $error("deep power-down not entered");

	a_partial_refresh_select_one_bank: assert property ( // [R7]
		(partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_QUAR || partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_EIGH)
			|-> (keep_bank_o == 4'h1) && (keep_row12_low_o == (partial_refresh_select == lpd_pkg::PARTIAL_REFRESH_SELECT_EIGH)))
		else $error("partial refresh region wrong");

	a_region_lost_cause: assert property ( // [R8]
		$rose(region_lost_o) |-> $past(self_refresh_o) && ($past(partial_refresh_select) != lpd_pkg::PARTIAL_REFRESH_SELECT_ALL))
		else $error("region lost without cause");

endmodule

// ### verif/lpd_ctrl_model.sv
// Controller side model driving the command pins on the link clock
module lpd_ctrl_model
(
	// Link clock
	input  wire logic   link_clk_i,
	// Command pins
	output logic        cke_o,
	output logic        cs_n_o,
	output logic        row_n_o,
	output logic        col_n_o,
	output logic        wr_n_o,
	output logic [1:0]  bank_o,
	output logic [12:0] addr_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle no-op from time zero
	initial
	begin
		cke_o = 1'b1;
		{cs_n_o, row_n_o, col_n_o, wr_n_o} = 4'h7;
		bank_o = 2'h0;
		addr_o = 13'h0000;
	end

	// One command for one link cycle, then no-op
	task automatic send(input lpd_pkg::lpd_pins_t p);
		@(negedge link_clk_i);
		// Enable only low when entering a power-saving state
		{cke_o, cs_n_o, row_n_o, col_n_o, wr_n_o, bank_o, addr_o} = p;
		@(negedge link_clk_i);
		// Released lines show inverted values under a no-op
		{cs_n_o, row_n_o, col_n_o, wr_n_o} = 4'h7;
		bank_o = ~p.bank;
		addr_o = ~p.addr;
		// Extra gap after a mode load
		if (p.cs_n == 1'b0 && {p.row_n, p.col_n, p.wr_n} == 3'h0)
			@(negedge link_clk_i);
	endtask
endmodule

// ### verif/test_lpd_command_decode_emr.sv
// Command decode bench with queued expectations
module test_lpd_command_decode_emr;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		lpd_pkg::lpd_op_t op;
		logic [1:0]       bk;
		logic [12:0]      ad;
		logic [4:0]       ln;
	} lpd_exp_t;

	// Reserved code first: it must keep every bank
	localparam logic [2:0] PARTIAL_REFRESH_SELECT_TAB [6] = '{3'h3, 3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
	localparam logic [5:0] KEEP_TAB [6] = '{6'h3c, 6'h3c, 6'h0c, 6'h04, 6'h06, 6'h07};

	logic             sys_clk_i = 1'b0;
	logic             link_clk_i = 1'b0;
	logic             srst_i, cke_i, cs_n_i, row_strobe_n_i, col_strobe_n_i, wr_strobe_n_i;
	logic [7:0]       die_temp_i;
	logic [1:0]       bank_i, cmd_bank_o, refresh_bank_o, output_drive_select_o;
	logic [12:0]      addr_i, cmd_addr_o, refresh_row_o;
	logic [31:0]      wr_data_i, wr_data_o;
	logic [3:0]       write_byte_mask_i, wr_byte_en_o, burst_start_o, keep_bank_o;
	logic             cmd_valid_o, auto_pre_o, pre_all_o, self_refresh_o, deep_pd_o;
	logic             sr_fast_o, keep_row12_low_o, keep_row11_low_o, region_lost_o;
	lpd_pkg::lpd_op_t cmd_op_o;
	logic [9:0]       cmd_col_o, burst_base_o;
	logic [4:0]       burst_len_o;
	logic [2:0]       partial_refresh_select_o;
	lpd_exp_t         exp_q [$];
	lpd_exp_t         e;
	logic [9:0]       m;
	int               error_cnt = 0;
	int               n_compared = 0;

	// Clocks; link period never changes
	always #10 sys_clk_i = ~sys_clk_i;
	initial
	begin
		#13;
		forever #32 link_clk_i = ~link_clk_i;
	end

	lpd_ctrl_model lpd_ctrl_model_i (.link_clk_i(link_clk_i), .cke_o(cke_i), .cs_n_o(cs_n_i),
		.row_n_o(row_strobe_n_i), .col_n_o(col_strobe_n_i), .wr_n_o(wr_strobe_n_i),
		.bank_o(bank_i), .addr_o(addr_i));

	lpd_cmd_decode #(.DATA_W(32), .RETAIN_CYC(20), .HOT_TEMP(8'h50)) lpd_cmd_decode_i (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .die_temp_i(die_temp_i),
		.link_clk_i(link_clk_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
		.row_strobe_n_i(row_strobe_n_i), .col_strobe_n_i(col_strobe_n_i),
		.wr_strobe_n_i(wr_strobe_n_i), .bank_i(bank_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .write_byte_mask_i(write_byte_mask_i),
		.wr_data_o(wr_data_o), .wr_byte_en_o(wr_byte_en_o),
		.cmd_valid_o(cmd_valid_o), .cmd_op_o(cmd_op_o), .cmd_bank_o(cmd_bank_o),
		.cmd_addr_o(cmd_addr_o), .cmd_col_o(cmd_col_o), .auto_pre_o(auto_pre_o),
		.pre_all_o(pre_all_o), .burst_base_o(burst_base_o),
		.burst_start_o(burst_start_o), .burst_len_o(burst_len_o),
		.refresh_row_o(refresh_row_o), .refresh_bank_o(refresh_bank_o),
		.self_refresh_o(self_refresh_o), .deep_pd_o(deep_pd_o), .sr_fast_o(sr_fast_o),
		.keep_bank_o(keep_bank_o), .keep_row12_low_o(keep_row12_low_o),
		.keep_row11_low_o(keep_row11_low_o), .region_lost_o(region_lost_o),
		.output_drive_select_o(output_drive_select_o),
		.partial_refresh_select_o(partial_refresh_select_o));

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Strobe levels row, column, write of each command
	function automatic logic [2:0] strobes(input lpd_pkg::lpd_op_t op);
		case (op)
			lpd_pkg::OP_OPEN:    return 3'h3;
			lpd_pkg::OP_READ:    return 3'h5;
			lpd_pkg::OP_WRITE:   return 3'h4;
			lpd_pkg::OP_BSTOP:   return 3'h6;
			lpd_pkg::OP_CLOSE:   return 3'h2;
			lpd_pkg::OP_REFRESH: return 3'h1;
			lpd_pkg::OP_MODE:    return 3'h0;
			default:             return 3'h7;
		endcase
	endfunction

	// Note expectation, then drive the command
	task automatic issue(input logic ck, input lpd_pkg::lpd_op_t op, input logic [1:0] bk,
		input logic [12:0] ad, input logic [4:0] ln);
		if (op != lpd_pkg::OP_NOP)
			exp_q.push_back({op, bk, ad, ln});
		lpd_ctrl_model_i.send({ck, 1'b0, strobes(op), bk, ad});
	endtask

	// Bounded wait until every noted command has appeared
	task automatic drain(input string nm);
		for (int i = 0; i < 400 && exp_q.size() != 0; i++)
			@(posedge sys_clk_i);
		if (exp_q.size() != 0)
		begin
			chk("pending commands", 32'h0, 32'(exp_q.size()));
			end_sim();
		end
		repeat (8) @(negedge sys_clk_i);
		$display("test %s finished", nm);
	endtask

	// Result watcher, sampling mid-cycle where outputs are settled
	always @(negedge sys_clk_i)
	begin
		if (cmd_valid_o === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("spurious pulse", 32'h0, 32'h1);
			else
			begin
				e = exp_q.pop_front();
				m = 10'(e.ln) - 10'h1;
				chk("op", 32'(e.op), 32'(cmd_op_o));
				if (e.op == lpd_pkg::OP_OPEN)
					chk("row", 32'({e.bk, e.ad}), 32'({cmd_bank_o, cmd_addr_o}));
				if (e.op == lpd_pkg::OP_MODE)
					chk("mode word", 32'({e.bk, e.ad}), 32'({cmd_bank_o, cmd_addr_o}));
				if (e.op == lpd_pkg::OP_CLOSE)
					chk("close", 32'({e.ad[10], e.ad[10] | (e.bk === cmd_bank_o)}),
						32'({pre_all_o, 1'b1}));
				if (e.ln != 5'h0)
				begin
					chk("column", 32'({e.bk, e.ad[10:0]}),
						32'({cmd_bank_o, auto_pre_o, cmd_col_o}));
					chk("burst", 32'({e.ad[9:0] & ~m, e.ad[3:0] & m[3:0], e.ln}),
						32'({burst_base_o, burst_start_o, burst_len_o}));
				end
			end
		end
	end

	// Main sequence
	initial
	begin
		logic [12:0] a;
		int          n;
		void'($urandom(32'hc9aa_04de));
		srst_i = 1'b1;
		die_temp_i = 8'h00;
		wr_data_i = 32'h0000_0000;
		write_byte_mask_i = 4'h0;
		repeat (12) @(negedge sys_clk_i);
		srst_i = 1'b0;
		repeat (4) @(negedge link_clk_i);
		chk("reset drive", 32'h0, 32'(output_drive_select_o));
		chk("reset keep", 32'h0000_003c, 32'({keep_bank_o, keep_row12_low_o, keep_row11_low_o}));
		issue(1'b1, lpd_pkg::OP_NOP, 2'h1, 13'($urandom), 5'h0);
		lpd_ctrl_model_i.send({1'b1, 1'b1, 3'h0, 2'h2, 13'h0000});
		drain("idle");
		for (int i = 1; i <= 4; i++)
		begin
			issue(1'b1, lpd_pkg::OP_MODE, 2'h0, 13'h0030 | 13'(i), 5'h0);
			issue(1'b1, lpd_pkg::OP_OPEN, 2'(i), 13'($urandom), 5'h0);
			issue(1'b1, lpd_pkg::OP_WRITE, 2'(i), 13'($urandom) | 13'h0400, 5'(2 << (i - 1)));
			issue(1'b1, lpd_pkg::OP_READ, 2'(i), 13'($urandom) & 13'h1bff, 5'(2 << (i - 1)));
		end
		issue(1'b1, lpd_pkg::OP_BSTOP, 2'h0, 13'h0000, 5'h0);
		issue(1'b1, lpd_pkg::OP_CLOSE, 2'h2, 13'h0000, 5'h0);
		issue(1'b1, lpd_pkg::OP_CLOSE, 2'h1, 13'h0400, 5'h0);
		drain("commands");
		for (int i = 0; i < 6; i++)
		begin
			a = {6'h00, 2'(i % 3), 2'($urandom), PARTIAL_REFRESH_SELECT_TAB[i]};
			issue(1'b1, lpd_pkg::OP_MODE, lpd_pkg::BANK_EXT, a, 5'h0);
			drain("extended load");
			chk("drive", 32'(a[6:5]), 32'(output_drive_select_o));
			chk("refresh select", 32'(a[2:0]), 32'(partial_refresh_select_o));
			chk("keep", 32'(KEEP_TAB[i]), 32'({keep_bank_o, keep_row12_low_o, keep_row11_low_o}));
		end
		// Reserved bank codes must leave both mode registers alone
		issue(1'b1, lpd_pkg::OP_MODE, 2'h1, 13'h1fff, 5'h0);
		issue(1'b1, lpd_pkg::OP_MODE, 2'h3, 13'h0000, 5'h0);
		issue(1'b1, lpd_pkg::OP_MODE, lpd_pkg::BANK_BASE, 13'h0031, 5'h0);
		drain("base load");
		chk("held select", 32'h0000_0006, 32'(partial_refresh_select_o));
		n = 1 + ($urandom % 5);
		for (int i = 0; i < n; i++)
			issue(1'b1, lpd_pkg::OP_REFRESH, 2'($urandom), 13'($urandom), 5'h0);
		drain("auto refresh");
		chk("refresh count", 32'(n), 32'({refresh_bank_o, refresh_row_o}));
		chk("lost early", 32'h0, 32'(region_lost_o));
		issue(1'b0, lpd_pkg::OP_REFRESH, 2'h0, 13'h0000, 5'h0);
		drain("self refresh");
		chk("self refresh", 32'h1, 32'(self_refresh_o));
		repeat (40) @(negedge sys_clk_i);
		chk("region lost", 32'h1, 32'(region_lost_o));
		issue(1'b1, lpd_pkg::OP_NOP, 2'h0, 13'h0000, 5'h0);
		repeat (8) @(negedge sys_clk_i);
		chk("self refresh exit", 32'h0, 32'(self_refresh_o));
		issue(1'b0, lpd_pkg::OP_BSTOP, 2'h0, 13'h0000, 5'h0);
		drain("deep power-down");
		chk("deep power-down", 32'h1, 32'(deep_pd_o));
		issue(1'b1, lpd_pkg::OP_NOP, 2'h0, 13'h0000, 5'h0);
		repeat (8) @(negedge sys_clk_i);
		chk("deep power-down exit", 32'h0, 32'(deep_pd_o));
		for (int i = 0; i < 8; i++)
		begin
			@(negedge link_clk_i);
			wr_data_i = $urandom;
			write_byte_mask_i = 4'($urandom);
			@(negedge link_clk_i);
			chk("byte enable", {28'h000_0000, ~write_byte_mask_i}, 32'(wr_byte_en_o));
			chk("data", wr_data_i, wr_data_o);
		end
		$display("test write mask finished");
		for (int i = 0; i < 8; i++)
		begin
			@(negedge sys_clk_i);
			die_temp_i = 8'($urandom);
			#1;
			chk("fast refresh", 32'(die_temp_i >= 8'h50), 32'(sr_fast_o));
		end
		$display("test temperature finished");
		end_sim();
	end
endmodule
